/* File: design/dmap_port.sv */
// Host memory access port with character, flash, glyph and control stores
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Hold 8 chars, 8 flash bits, 16 user glyphs.
// - Select high, upper lines 11: character memory, low lines pick digit.
// - Char bit 7 low means ASCII code; high means glyph index bits 3..0.
// - Select high, upper 00: glyph pointer register, low lines ignored.
// - Row accesses use glyph index held in pointer register.
// - Select high, upper 01: glyph row memory, rows 000 to 110.
// - Rows keep data bits 4..0, bit 0 is rightmost column.
// - Attribute select low: flash memory, upper lines ignored.
// - Flash write stores data bit 0 for the addressed digit.
// - Control bit 3 and flash bit make digit flash at clock/28672.
// - Select high, upper 10: control word, low lines ignored.
// - Reset fills chars with 20h, clears flash, control and flash timebase; glyph rows and pointer keep their values.
module dmap_port
  import dmap_pkg::*;
#(
  parameter int FLASH_DIVIDE = dmap_pkg::FLASH_DIV
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Host strobes and address
  input wire logic chip_sel_n_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic attribute_select_n_in,
  input wire logic [4:0] addr_in,
  // Data bus, split
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // Display clock tick and per-digit state
  input wire logic disp_clk_tick_in,
  output logic [7:0] digit_visible_out,
  output logic [7:0] control_word_out,
  output logic [7:0] digit_code_out,
  input wire logic [2:0] scan_digit_in
);
  import dmap_pkg::*;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] wr_s;
    logic [2:0] rd_s;
    logic [1:0] fl_s;
    logic [9:0] a_s;
    logic [15:0] d_s;
    dmap_state_e st;
    logic [7:0][7:0] chars;
    logic [7:0] flash;
    logic [7:0] ctrl;
    logic [7:0] dout;
    logic oe;
    logic [DIV_W-1:0] div;
    logic phase;
    logic [7:0] vis;
    logic [7:0] code;
  } dmap_s;

  dmap_s q, d;
  logic [4:0] glyph_mem [16][7];
  logic glyph_we;
  logic [3:0] glyph_idx;
  logic [2:0] glyph_row;
  logic [4:0] glyph_wdata;
  logic [7:0] ptr_q;
  logic ptr_we;
  logic [7:0] ptr_wdata;

  // Decode the section from the synchronised select and upper lines
  function automatic logic [2:0] section(input logic fl_n,
                                         input logic [1:0] up);
    if (fl_n) begin
      section = {1'b0, up};
    end else begin
      section = 3'h4;
    end
  endfunction

  // Row code 111 has no storage behind it
  function automatic logic row_ok(input logic [2:0] row);
    row_ok = (row <= ROW_LAST);
  endfunction

  always_comb begin
    logic fl;
    logic [4:0] a;
    logic [7:0] w;
    logic [2:0] sec;
    logic [2:0] lo;
    fl = q.fl_s[1];
    a = q.a_s[9:5];
    w = q.d_s[15:8];
    lo = a[2:0];
    sec = section(fl, a[4:3]);
    d = q;
    glyph_we = 1'b0;
    ptr_we = 1'b0;
    ptr_wdata = w;
    glyph_idx = ptr_q[3:0];
    glyph_row = lo;
    glyph_wdata = w[4:0];

    // Only the second stage of each synchroniser feeds the decode
    d.cs_s = {q.cs_s[1:0], chip_sel_n_in};
    d.wr_s = {q.wr_s[1:0], wr_n_in};
    d.rd_s = {q.rd_s[1:0], rd_n_in};
    d.fl_s = {q.fl_s[0], attribute_select_n_in};
    d.a_s = {q.a_s[4:0], addr_in};
    d.d_s = {q.d_s[7:0], data_in};

    // Strobes are async, so act once per chip-select low period
    unique case (q.st)
      DMAP_IDLE: begin
        d.oe = 1'b0;
        if (!q.cs_s[1] && (q.wr_s[1] ^ q.rd_s[1])) begin
          d.st = DMAP_ACC;
        end
      end
      DMAP_ACC: begin
        if (q.cs_s[1]) begin
          d.st = DMAP_IDLE;
        end else if (!q.wr_s[1] && q.rd_s[1]) begin
          // Write lands on the synchronised data at this point
          unique case (sec)
            3'h3: d.chars[lo] = w;
            3'h0: ptr_we = 1'b1;
            3'h1: glyph_we = row_ok(lo);
            3'h2: d.ctrl = w;
            default: d.flash[lo] = w[0];
          endcase
          d.st = DMAP_DONE;
        end else if (q.wr_s[1] && !q.rd_s[1]) begin
          unique case (sec)
            3'h3: d.dout = q.chars[lo];
            3'h0: d.dout = {4'h0, ptr_q[3:0]};
            3'h1: d.dout = row_ok(lo) ?
                           {3'h0, glyph_mem[ptr_q[3:0]][lo]} : 8'h00;
            3'h2: d.dout = q.ctrl;
            default: d.dout = {7'h00, q.flash[lo]};
          endcase
          d.oe = 1'b1;
          d.st = DMAP_DONE;
        end else begin
          d.st = DMAP_IDLE;
        end
      end
      DMAP_DONE: begin
        // Hold read data until the strobe rises; one write per cycle
        if (q.cs_s[1] || q.rd_s[1]) begin
          d.oe = 1'b0;
        end
        if (q.cs_s[1]) begin
          d.st = DMAP_IDLE;
        end
      end
      default: d.st = DMAP_IDLE;
    endcase

    // Flash timebase counted in display clock ticks
    if (disp_clk_tick_in) begin
      if (q.div == DIV_W'(FLASH_DIVIDE / 2 - 1)) begin
        d.div = '0;
        d.phase = ~q.phase;
      end else begin
        d.div = q.div + 1'b1;
      end
    end
    // A flashing digit goes dark in the second half of each period
    for (int i = 0; i < 8; i++) begin
      d.vis[i] = ~(q.ctrl[CTRL_FLASH_EN_BIT] & q.flash[i] & q.phase);
    end

    // Scan index is on this clock already, so it needs no sync
    d.code = q.chars[scan_digit_in];
  end

  // Glyph store survives reset, so it sits outside the reset process
  always_ff @(posedge core_clk_in) begin
    if (glyph_we) begin
      glyph_mem[glyph_idx][glyph_row] <= glyph_wdata;
    end
  end

  // Reset leaves the pointer alone, so it has no reset branch either
  always_ff @(posedge core_clk_in) begin
    if (ptr_we) begin
      ptr_q <= ptr_wdata;
    end
  end

  // Async reset; only constants in the reset branch

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.cs_s <= 3'h7;
      q.wr_s <= 3'h7;
      q.rd_s <= 3'h7;
      q.fl_s <= 2'h3;
      q.st <= DMAP_IDLE;
      q.chars <= {8{CHAR_RESET}};
      q.ctrl <= CTRL_RESET;
      q.vis <= 8'hff;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  assign data_out = q.dout;
  assign data_oe_out = q.oe;
  assign digit_visible_out = q.vis;
  assign control_word_out = q.ctrl;
  assign digit_code_out = q.code;
endmodule // dmap_port
`default_nettype wire

/* File: pkg/dmap_pkg.sv */
// Constants and types for the display memory access port
package dmap_pkg;
  // Section select codes on the two upper address lines
  localparam logic [1:0] SEL_POINTER = 2'h0;
  localparam logic [1:0] SEL_ROWS = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_CHAR = 2'h3;
  // Field positions
  localparam int CHAR_KIND_BIT = 7;
  localparam int CTRL_FLASH_EN_BIT = 3;
  // Reset and fill values
  localparam logic [7:0] CHAR_RESET = 8'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] ROW_LAST = 3'h6;
  // Flash period in display clock cycles
  localparam int FLASH_DIV = 28672;
  localparam int HALF_FLASH = FLASH_DIV / 2;
  localparam int DIV_W = 15;
  localparam int DISP_CLK_PER_CORE = 350;
  typedef enum logic [2:0] {
    DMAP_IDLE = 3'b001,
    DMAP_ACC = 3'b010,
    DMAP_DONE = 3'b100
  } dmap_state_e;
endpackage : dmap_pkg

/* File: sim/dmap_port_properties.sv */
// Port assertions for the display memory access port
`timescale 1ns/10ps
`default_nettype none
module dmap_port_properties import dmap_pkg::*; (
  input wire logic core_clk_in, arst_n_in, chip_sel_n_in, rd_n_in, wr_n_in,
  input wire logic attribute_select_n_in, data_oe_out,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] data_out, digit_visible_out, control_word_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence rd_on; !chip_sel_n_in && !rd_n_in && wr_n_in; endsequence
  sequence sel(s); data_oe_out && attribute_select_n_in && addr_in[4:3] == s;
  endsequence
  AST_RST: assert property (
    $rose(arst_n_in) |-> control_word_out == CTRL_RESET) else $error("ctrl");
  AST_OE_READ: assert property (
    rd_on [*8] |-> data_oe_out) else $error("no read drive");
  AST_OE_WRITE: assert property (
    (!chip_sel_n_in && rd_n_in) [*7] |-> !data_oe_out) else $error("drive");
  AST_OE_IDLE: assert property (
    chip_sel_n_in [*6] |-> !data_oe_out) else $error("idle drive");
  AST_CTRL: assert property (
    chip_sel_n_in [*8] |-> $stable(control_word_out)) else $error("ctrl");
  AST_PTR: assert property (
    sel(SEL_POINTER) |-> data_out[7:4] == 4'h0) else $error("ptr");
  AST_ROW: assert property (
    sel(SEL_ROWS) |-> data_out[7:5] == 3'h0) else $error("row");
  AST_FLASH: assert property (
    data_oe_out && !attribute_select_n_in |-> data_out[7:1] == 7'h0)
    else $error("flash");
  AST_VIS: assert property (
    !control_word_out[CTRL_FLASH_EN_BIT] [*2] |-> digit_visible_out == 8'hff)
    else $error("vis");
endmodule // dmap_port_properties
`default_nettype wire

/* File: sim/dmap_host.sv */
// Host bus master model
`timescale 1ns/10ps
`default_nettype none
module dmap_host (
  input wire logic clk_in,
  output logic cs_n_out, wr_n_out, rd_n_out, fl_n_out,
  output logic [4:0] addr_out,
  output logic [7:0] data_out
);
  initial {cs_n_out, wr_n_out, rd_n_out, fl_n_out, addr_out, data_out} = '1;
  // Address is kept until the next access so it never moves under select
  task automatic access(logic w, logic f, logic [4:0] a, logic [7:0] d);
    @(posedge clk_in);
    #1 {fl_n_out, addr_out, data_out} = {f, a, d};
    {cs_n_out, wr_n_out, rd_n_out} = {1'b0, !w, w};
    repeat (9) @(posedge clk_in);
    #1 {cs_n_out, wr_n_out, rd_n_out} = 3'h7;
    data_out = ~d;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // dmap_host
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking testbench for the display memory access port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dmap_pkg::*;
  logic clk = 0, rst_n = 0, cs_n, wr_n, rd_n, fl_n, tick = 0, oe, seen = 0;
  logic [4:0] a;
  logic [7:0] din, dout, m[8], q[$];
  logic [7:0] ctrl, vis, code, dark;
  int n_fail = 0, samples_checked = 0, cyc = 0, seed = 38;
  initial forever #25 clk = ~clk;
  always @(posedge clk) #1 tick = 1'($random(seed));
  dmap_host host_u (.clk_in(clk), .cs_n_out(cs_n), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .fl_n_out(fl_n), .addr_out(a), .data_out(din));
  dmap_port #(.FLASH_DIVIDE(8)) dut_u (.core_clk_in(clk), .arst_n_in(rst_n),
    .chip_sel_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
    .attribute_select_n_in(fl_n), .addr_in(a), .data_in(din),
    .data_out(dout), .data_oe_out(oe), .disp_clk_tick_in(tick),
    .digit_visible_out(vis), .control_word_out(ctrl), .digit_code_out(code),
    .scan_digit_in(a[2:0]));
  task automatic check(logic [7:0] e);
    samples_checked++;
    if (dout !== e) begin
      n_fail++;
      $display("[FAIL] data_out exp %h got %h", e, dout);
    end
  endtask
  task automatic check_out(string nm, logic [7:0] e, logic [7:0] got);
    samples_checked++;
    if (got !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, got);
    end
  endtask
  always @(negedge clk) begin
    if (oe === 1'b1 && !seen) check(q.pop_front());
    seen = (oe === 1'b1);
  end
  task automatic wr(logic f, logic [4:0] ad, logic [7:0] d);
    host_u.access(1'b1, f, ad, d);
  endtask
  task automatic rd(logic f, logic [4:0] ad, logic [7:0] e);
    q.push_back(e);
    host_u.access(1'b0, f, ad, 8'($random(seed)));
  endtask
  task automatic summarize;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    rd(1, 5'h1d, CHAR_RESET);
    rd(0, 5'h05, 8'h00);
    for (int i = 0; i < 8; i++) begin
      m[i] = 8'($random(seed));
      wr(1, {SEL_CHAR, 3'(i)}, m[i]);
    end
    for (int i = 0; i < 8; i++) begin
      rd(1, {SEL_CHAR, 3'(i)}, m[i]);
      check_out("digit_code_out", m[i], code);
    end
    wr(1, 5'h07, 8'hfa);
    for (int i = 0; i < 7; i++) begin
      m[i] = 8'($random(seed));
      wr(1, {SEL_ROWS, 3'(i)}, m[i]);
    end
    wr(1, 5'h00, 8'h03);
    wr(1, 5'h08, 8'h00);
    wr(1, 5'h05, 8'hfa);
    rd(1, 5'h02, 8'h0a);
    for (int i = 0; i < 7; i++) rd(1, {SEL_ROWS, 3'(i)}, m[i] & 8'h1f);
    wr(0, 5'h1a, 8'hff);
    rd(0, 5'h02, 8'h01);
    wr(0, 5'h0a, 8'hfe);
    rd(0, 5'h12, 8'h00);
    wr(1, 5'h17, 8'h08);
    check_out("control_word_out", 8'h08, ctrl);
    rd(1, 5'h10, 8'h08);
    wr(0, 5'h03, 8'h01);
    dark = '0;
    repeat (64) @(negedge clk) dark |= ~vis;
    check_out("digit_visible_out", 8'h08, dark);
    wr(1, 5'h10, 8'h00);
    dark = '0;
    repeat (32) @(negedge clk) dark |= ~vis;
    check_out("digit_visible_out", 8'h00, dark);
    #1 rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    check_out("control_word_out", CTRL_RESET, ctrl);
    rd(1, 5'h1a, CHAR_RESET);
    rd(0, 5'h03, 8'h00);
    rd(1, 5'h04, 8'h0a);
    summarize;
  end
endmodule // testbench
bind dmap_port dmap_port_properties chk_u (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .chip_sel_n_in(chip_sel_n_in), .rd_n_in(rd_n_in),
  .wr_n_in(wr_n_in), .attribute_select_n_in(attribute_select_n_in),
  .data_oe_out(data_oe_out), .addr_in(addr_in), .data_out(data_out),
  .digit_visible_out(digit_visible_out),
  .control_word_out(control_word_out));
`default_nettype wire
